/* File: stb_pkg.sv */
package stb_pkg;
    // timer bank geometry
    localparam int NUM_TIMERS = 8;
    localparam int NUM_GP = 3;
    localparam int CNT_W = 32;
    // dedicated timer widths (3 watchdog, 4/5 bus time-outs, 6 refresh, 7 warm reset)
    localparam logic [5:0] DED_W [3:7] = '{6'd16, 6'd16, 6'd16, 6'd16, 6'd16};
    localparam logic [7:0] DED_W8 = 8'd8;
    // register map: timer n at n*STRIDE, words within the set
    localparam logic [7:0] STRIDE = 8'h10;
    localparam logic [3:0] OFF_COUNT = 4'h0;
    localparam logic [3:0] OFF_MATCH = 4'h4;
    localparam logic [3:0] OFF_CTRL = 4'h8;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h80;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
    localparam logic [7:0] OFF_RAW_STAT = 8'h88;
    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GATE_BIT = 1;
    // reset values
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] MATCH_RST = 32'hffff_ffff;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // warm-reset timer index and its default delay
    localparam int WARM_IDX = 7;
    localparam logic [31:0] WARM_MATCH_RST = 32'h0000_00ff;
    // lane width masks for dedicated timers
    localparam logic [31:0] MASK16 = 32'h0000_ffff;
    localparam logic [31:0] MASK8 = 32'h0000_00ff;
endpackage

/* File: stb_tmr_if.sv */
`timescale 1ns/1ns
`default_nettype none
// one timer's control and status as a bundle
interface stb_tmr_if;
    logic enable;
    logic gate_mode;
    logic gate_n;
    logic [31:0] match_value;
    logic [31:0] width_mask;
    logic load;
    logic [31:0] load_value;
    logic [31:0] count;
    logic match_n;
    modport ctl (output enable, gate_mode, gate_n, match_value, width_mask, load, load_value,
                 input count, match_n);
    modport core (input enable, gate_mode, gate_n, match_value, width_mask, load, load_value,
                  output count, match_n);
endinterface
`default_nettype wire

/* File: stb_timer_core.sv */
`timescale 1ns/1ns
`default_nettype none
// single up-counter with compare, wrap and one-clock active-low match pulse
module stb_timer_core (
    input wire logic pclk,
    input wire logic rst_n,
    stb_tmr_if.core t
);
    import stb_pkg::*;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic tick;
    logic hit;

    // tick decode: gate pin used directly as an enable, no sync stage
    assign tick = t.enable & (~t.gate_mode | ~t.gate_n);
    assign hit = tick & ((count_reg & t.width_mask) == (t.match_value & t.width_mask));
    assign count_next = hit ? COUNT_RST : ((count_reg + 32'h0000_0001) & t.width_mask);

    // count register, cleared on reset
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= COUNT_RST;
        end else if (t.load) begin
            count_reg <= t.load_value & t.width_mask;
        end else if (tick) begin
            count_reg <= count_next;
        end
    end

    assign t.count = count_reg;
    assign t.match_n = ~hit;
endmodule // stb_timer_core
`default_nettype wire

/* File: stb_timer_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module stb_timer_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_on_reset_in_n,
    input wire logic soft_restart,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] gate_in_n,
    input wire logic [1:0] pin_dir_out,
    output logic [1:0] terminal_match_out_n,
    output logic [1:0] terminal_match_oe,
    output logic watchdog_match_n,
    output logic processor_bus_fault_match_n,
    output logic internal_bus_fault_match_n,
    output logic refresh_match_n,
    output logic system_reset_out_n,
    output logic irq
);
    import stb_pkg::*;

    logic [31:0] match_reg [NUM_TIMERS];
    logic [1:0] ctrl_reg [NUM_TIMERS];
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_mask_reg;
    logic [1:0] pin_match_reg;
    logic warm_rst_n;
    logic [7:0] match_n_w;
    logic [31:0] count_w [NUM_TIMERS];
    logic wr_en;
    logic rd_en;
    logic [2:0] sel_idx;
    logic [3:0] sel_off;
    logic is_timer;
    logic addr_ok;
    logic [7:0] stat_wr_clear;
    logic [31:0] rdata_mux;
    logic [7:0] event_w;

    // lane mask per timer width
    function automatic logic [31:0] width_mask_of(input int idx);
        if (idx < NUM_GP) begin
            return 32'hffff_ffff;
        end
        return (idx == 6) ? MASK8 : MASK16;
    endfunction

    // apb decode, zero-wait answer
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~pwrite;
    assign sel_idx = paddr[6:4];
    assign sel_off = paddr[3:0];
    assign is_timer = ~paddr[7] & ((sel_off == OFF_COUNT) | (sel_off == OFF_MATCH)
                      | (sel_off == OFF_CTRL));
    assign addr_ok = is_timer | (paddr == OFF_IRQ_STAT) | (paddr == OFF_IRQ_MASK)
                     | (paddr == OFF_RAW_STAT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // warm reset domain: system reset held low by warm restart or until timer 7 matches
    logic sys_rst_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_reg <= 1'b0;
        end else if (!power_on_reset_in_n || soft_restart) begin
            sys_rst_reg <= 1'b0;
        end else if (!match_n_w[WARM_IDX]) begin
            sys_rst_reg <= 1'b1;
        end
    end
    assign system_reset_out_n = sys_rst_reg;
    assign warm_rst_n = presetn;

    // timer instances
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
            stb_tmr_if tif ();
            logic ld;
            assign ld = wr_en & is_timer & (sel_idx == 3'(gi)) & (sel_off == OFF_COUNT);
            if (gi == WARM_IDX) begin : g_warm
                // counts while power-on reset released and system reset still held
                assign tif.enable = power_on_reset_in_n & ~sys_rst_reg;
                assign tif.gate_mode = 1'b0;
                assign tif.load = ld; // warm restart never reloads the delay timer
            end else begin : g_norm
                assign tif.enable = ctrl_reg[gi][CTRL_EN_BIT];
                assign tif.gate_mode = (gi < 2) ? ctrl_reg[gi][CTRL_GATE_BIT] : 1'b0;
                assign tif.load = ld;
            end
            if (gi == 1) begin : g_casc
                assign tif.gate_n = match_n_w[0];
            end else if (gi == 0) begin : g_pin
                assign tif.gate_n = gate_in_n[0];
            end else begin : g_nopin
                assign tif.gate_n = 1'b1;
            end
            assign tif.match_value = match_reg[gi];
            assign tif.width_mask = width_mask_of(gi);
            assign tif.load_value = pwdata;
            assign count_w[gi] = tif.count;
            assign match_n_w[gi] = tif.match_n;
            stb_timer_core u_core (
                .pclk(pclk),
                .rst_n((gi == WARM_IDX) ? presetn : warm_rst_n),
                .t(tif)
            );
        end
    endgenerate

    // match, control and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                match_reg[i] <= (i == WARM_IDX) ? WARM_MATCH_RST : MATCH_RST;
                ctrl_reg[i] <= CTRL_RST;
            end
            irq_mask_reg <= 8'h00;
        end else if (wr_en) begin
            if (is_timer && sel_off == OFF_MATCH) begin
                match_reg[sel_idx] <= pwdata & width_mask_of(int'(sel_idx));
            end
            if (is_timer && sel_off == OFF_CTRL) begin
                ctrl_reg[sel_idx] <= pwdata[1:0];
            end
            if (paddr == OFF_IRQ_MASK) begin
                irq_mask_reg <= pwdata[7:0];
            end
        end
    end

    // sticky match events, write one to clear, set wins
    assign event_w = ~match_n_w;
    assign stat_wr_clear = (wr_en && paddr == OFF_IRQ_STAT) ? pwdata[7:0] : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 8'h00;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~stat_wr_clear) | event_w;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // registered match pins for timers 0 and 1, gate input by default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_match_reg <= 2'h3;
        end else begin
            pin_match_reg <= match_n_w[1:0];
        end
    end
    assign terminal_match_out_n = pin_match_reg;
    assign terminal_match_oe = pin_dir_out;

    // dedicated peripheral hookups
    assign watchdog_match_n = match_n_w[3];
    assign processor_bus_fault_match_n = match_n_w[4];
    assign internal_bus_fault_match_n = match_n_w[5];
    assign refresh_match_n = match_n_w[6];

    // read mux
    always_comb begin
        rdata_mux = 32'h0000_0000;
        if (is_timer) begin
            unique case (sel_off)
                OFF_COUNT: rdata_mux = count_w[sel_idx];
                OFF_MATCH: rdata_mux = match_reg[sel_idx];
                default: rdata_mux = {30'h0, ctrl_reg[sel_idx]};
            endcase
        end else if (paddr == OFF_IRQ_STAT) begin
            rdata_mux = {24'h0, irq_stat_reg};
        end else if (paddr == OFF_IRQ_MASK) begin
            rdata_mux = {24'h0, irq_mask_reg};
        end else if (paddr == OFF_RAW_STAT) begin
            rdata_mux = {24'h0, match_n_w};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= rdata_mux;
        end
    end

    // checks
    property p_pin_delay;
        @(posedge pclk) disable iff (!presetn) !match_n_w[0] |=> !terminal_match_out_n[0];
    endproperty
    a_pin_delay: assert property (p_pin_delay) else $error("pin match not delayed");
    property p_pulse_one;
        @(posedge pclk) disable iff (!presetn)
            (!match_n_w[2] && match_reg[2] != 32'h0) |=> match_n_w[2];
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("match pulse too long");
    property p_wrap;
        @(posedge pclk) disable iff (!presetn) !match_n_w[2] |=> count_w[2] == COUNT_RST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap");
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
            (!ctrl_reg[2][CTRL_EN_BIT] && !wr_en) |=> $stable(count_w[2]);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled timer moved");
    property p_gate;
        @(posedge pclk) disable iff (!presetn)
            (ctrl_reg[0] == 2'h3 && gate_in_n[0] && !wr_en) |=> $stable(count_w[0]);
    endproperty
    a_gate: assert property (p_gate) else $error("gated timer moved");

    // helper flags for the cascade and gate checks
    logic t1_cascade;
    logic t0_gated;
    assign t1_cascade = ctrl_reg[1][CTRL_EN_BIT] & ctrl_reg[1][CTRL_GATE_BIT];
    assign t0_gated = ctrl_reg[0][CTRL_EN_BIT] & ctrl_reg[0][CTRL_GATE_BIT];

    // pin pulse: low for one clock, then back high
    sequence s_pin_pulse;
        !terminal_match_out_n[0] ##1 terminal_match_out_n[0];
    endsequence
    // internal timer 0 match with a nonzero compare and no bus write
    sequence s_t0_clean_match;
        !match_n_w[0] && match_reg[0] != COUNT_RST && !wr_en;
    endsequence
    property p_pin_pulse;
        @(posedge pclk) disable iff (!presetn) s_t0_clean_match |=> s_pin_pulse;
    endproperty
    a_pin_pulse: assert property (p_pin_pulse) else $error("pin pulse not one clock");

    // timer 0 wraps to zero right after its match
    property p_wrap0;
        @(posedge pclk) disable iff (!presetn) (!match_n_w[0] && !wr_en) |=> count_w[0] == COUNT_RST;
    endproperty
    a_wrap0: assert property (p_wrap0) else $error("timer 0 did not wrap");

    // cascade: timer 1 holds between timer 0 matches
    property p_casc_hold;
        @(posedge pclk) disable iff (!presetn)
            (t1_cascade && match_n_w[0] && !wr_en) |=> $stable(count_w[1]);
    endproperty
    a_casc_hold: assert property (p_casc_hold) else $error("cascaded timer moved");

    // cascade: timer 1 steps once per timer 0 match
    property p_casc_step;
        @(posedge pclk) disable iff (!presetn)
            (t1_cascade && !match_n_w[0] && match_n_w[1] && !wr_en)
            |=> count_w[1] == $past(count_w[1]) + 32'h0000_0001;
    endproperty
    a_casc_step: assert property (p_casc_step) else $error("cascaded timer missed a step");

    // gate low moves the count at the very next edge, no sync delay
    property p_gate_step;
        @(posedge pclk) disable iff (!presetn)
            (t0_gated && !gate_in_n[0] && match_n_w[0] && !wr_en)
            |=> count_w[0] == $past(count_w[0]) + 32'h0000_0001;
    endproperty
    a_gate_step: assert property (p_gate_step) else $error("gated timer did not step");

    // watchdog match lasts one clock
    property p_wdog_one;
        @(posedge pclk) disable iff (!presetn)
            (!watchdog_match_n && match_reg[3] != COUNT_RST && !wr_en) |=> watchdog_match_n;
    endproperty
    a_wdog_one: assert property (p_wdog_one) else $error("watchdog pulse too long");

    // disabled watchdog never matches
    property p_wdog_quiet;
        @(posedge pclk) disable iff (!presetn) !ctrl_reg[3][CTRL_EN_BIT] |-> watchdog_match_n;
    endproperty
    a_wdog_quiet: assert property (p_wdog_quiet) else $error("disabled watchdog matched");

    // disabled timer 2 never matches
    property p_t2_quiet;
        @(posedge pclk) disable iff (!presetn) !ctrl_reg[2][CTRL_EN_BIT] |-> match_n_w[2];
    endproperty
    a_t2_quiet: assert property (p_t2_quiet) else $error("disabled timer 2 matched");

    // processor bus time-out match lasts one clock
    property p_pbus_one;
        @(posedge pclk) disable iff (!presetn)
            (!processor_bus_fault_match_n && match_reg[4] != COUNT_RST && !wr_en)
            |=> processor_bus_fault_match_n;
    endproperty
    a_pbus_one: assert property (p_pbus_one) else $error("bus time-out pulse too long");

    // match event lands in the status register, set wins
    property p_stat_set;
        @(posedge pclk) disable iff (!presetn) !match_n_w[0] |=> irq_stat_reg[0];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("match event not recorded");

    // reset out stays low while power-on reset is held
    property p_por_hold;
        @(posedge pclk) disable iff (!presetn) !power_on_reset_in_n |=> !system_reset_out_n;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("reset out released early");

    // timer 7 counts each clock between power-on release and reset out release
    property p_delay_count;
        @(posedge pclk) disable iff (!presetn)
            (power_on_reset_in_n && !system_reset_out_n && match_n_w[WARM_IDX] && !wr_en)
            |=> count_w[WARM_IDX] == $past(count_w[WARM_IDX]) + 32'h0000_0001;
    endproperty
    a_delay_count: assert property (p_delay_count) else $error("reset delay timer stalled");

    // timer 7 match releases reset out
    property p_delay_release;
        @(posedge pclk) disable iff (!presetn)
            (power_on_reset_in_n && !soft_restart && !match_n_w[WARM_IDX]) |=> system_reset_out_n;
    endproperty
    a_delay_release: assert property (p_delay_release) else $error("reset out not released");

    // warm restart leaves the reset delay count alone
    property p_warm_keep;
        @(posedge pclk) disable iff (!presetn)
            (soft_restart && system_reset_out_n && !wr_en) |=> $stable(count_w[WARM_IDX]);
    endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("warm restart moved delay timer");
endmodule // stb_timer_bank
`default_nettype wire

/* File: stb_pin_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// external pin side: gate driver and pin direction setting
module stb_pin_partner (
    input wire logic pclk,
    input wire logic go,
    output logic [1:0] gate_in_n,
    output logic [1:0] pin_dir_out
);
    // pins left as gate inputs, never turned to outputs
    assign pin_dir_out = 2'b00;
    // gate idles high until the first edge
    initial gate_in_n = 2'b11;
    // active-low gate, launched just after the edge
    always @(posedge pclk) begin
        gate_in_n <= {1'b1, ~go};
    end
endmodule // stb_pin_partner
`default_nettype wire

/* File: tb_system_timer_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_system_timer_bank;
    import stb_pkg::*;
    logic pclk, presetn, power_on_reset_in_n, soft_restart, psel, penable, pwrite, pready;
    logic pslverr, err, go, irq, system_reset_out_n, watchdog_match_n, refresh_match_n;
    logic processor_bus_fault_match_n, internal_bus_fault_match_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, m, g;
    logic [1:0] gate_in_n, pin_dir_out, terminal_match_out_n, terminal_match_oe;
    int errors, compares, cycles;
    int seed = 32'h2b8ee5c0;
    stb_timer_bank i_stb_timer_bank (.pclk, .presetn, .power_on_reset_in_n, .soft_restart,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gate_in_n,
        .pin_dir_out, .terminal_match_out_n, .terminal_match_oe, .watchdog_match_n,
        .processor_bus_fault_match_n, .internal_bus_fault_match_n, .refresh_match_n,
        .system_reset_out_n, .irq);
    stb_pin_partner i_stb_pin_partner (.pclk, .go, .gate_in_n, .pin_dir_out);
    // clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results;
        end
    end
    // compare and report
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one apb transfer, read data and error taken at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function logic pin(input int s);
        if (s == 2) return processor_bus_fault_match_n;
        return (s == 0) ? terminal_match_out_n[0] : watchdog_match_n;
    endfunction
    // clocks from one match pulse to the next, pulse one clock wide
    task period(input int s, input logic [31:0] exp);
        int n;
        n = 0;
        while (pin(s) !== 1'b0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n == 1) chk(pin(s), 32'h1);
        end while (pin(s) !== 1'b0 && n < 300);
        chk(n, exp);
    endtask
    // main sequence
    initial begin
        {presetn, power_on_reset_in_n, soft_restart, psel, penable, pwrite, go} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        power_on_reset_in_n <= 1'b1;
        @(posedge pclk);
        chk(system_reset_out_n, 32'h0);
        chk(terminal_match_oe, 32'h0);
        chk({internal_bus_fault_match_n, refresh_match_n, terminal_match_out_n}, 32'hf);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, COUNT_RST);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, MATCH_RST);
        apb(1'b0, 8'hf0, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        // gate mode: count only while the gate is low
        g = 32'h1 + ($random(seed) & 32'hf);
        apb(1'b1, 8'h08, 32'h3);
        repeat (4) @(posedge pclk);
        go <= 1'b1;
        repeat (g) @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, g);
        apb(1'b1, 8'h08, 32'h0);
        repeat (5) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, g);
        // timer 0 period, interrupt raised
        m = 32'h3 + ($random(seed) & 32'h7);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, m);
        apb(1'b1, 8'h84, 32'h1);
        apb(1'b1, 8'h08, 32'h1);
        period(0, m + 32'h1);
        chk(irq, 32'h1);
        // cascade: timer 1 counts timer 0 matches
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h18, 32'h3);
        apb(1'b1, 8'h08, 32'h1);
        repeat (3) period(0, m + 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h4);
        // interrupt masked, then cleared
        apb(1'b1, 8'h84, 32'h0);
        chk(irq, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        chk(rd[0], 32'h1);
        apb(1'b1, 8'h80, 32'h1);
        apb(1'b0, 8'h80, 32'h0);
        chk(rd[0], 32'h0);
        // watchdog timer on its dedicated output
        m = 32'h3 + ($random(seed) & 32'h7);
        apb(1'b1, 8'h24, m);
        apb(1'b1, 8'h28, 32'h1);
        apb(1'b1, 8'h34, m);
        apb(1'b1, 8'h38, 32'h1);
        period(1, m + 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd <= m, 32'h1);
        apb(1'b1, 8'h28, 32'h0);
        // processor bus time-out timer reused as a plain timer
        apb(1'b1, 8'h44, m);
        apb(1'b1, 8'h48, 32'h1);
        period(2, m + 32'h1);
        // reset delay expired, warm restart pulls reset out low
        repeat (300) @(posedge pclk);
        chk(system_reset_out_n, 32'h1);
        soft_restart <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(system_reset_out_n, 32'h0);
        soft_restart <= 1'b0;
        results;
    end
endmodule // tb_system_timer_bank
`default_nettype wire
